/* File: core/rdcfg_regs.sv */
// Configuration register bank, offsets 0x00 to 0x07, fed by decoded frames.
// Assumes frames arrive synchronous to sys_clk as one-cycle strobes.
`default_nettype none

// Functional notes
// - The identifier is read-only, eight bits, fixed, and untouched by any reset.
// - Bits 7..2 of the topology register pick high side (1) or low side (0) for channels 7..2.
// - Bit 1 of the topology register lets the external disable pin act when 1.
// - Bit 0 of the topology register lets the external reset pin reset registers when 1.
// - Writing 1 to bit 7 of the second register resets the bank and the bit clears itself.
// - All configuration fields return to defaults on power-on, pin, soft or undervoltage reset.
// - Bit 6 of the second register requests and holds active mode while set.
// - Two-bit dividers pick 122.5, 245.1, 490.2 or 980.4 Hz for the two generators.
// - Trim code 01 lowers and 10 raises the generator frequency by 15 percent.
// - In each per-channel register bit n controls output channel n.
// - The inrush register enables inrush mode per channel and resets to zero.
// - The output control register switches channels on and resets to all off.
// - The input-zero mapping register makes channels follow input zero, reset 0x04.
// - The reserved register and unused bits read as zero.
// - Frames are 16 bits: command, 5 address, 8 data, parity, frame toggle.
// - Parity is odd over frame bits 15 to 1 and is checked on receipt.
module rdcfg_regs (
   input  wire logic                    sys_clk,
   input  wire logic                    resetn,
   input  wire logic                    logicSupplyUndervoltage,
   input  wire logic                    externalResetPin_n,
   input  wire logic                    externalDisablePin_n,
   input  wire logic                    parallelInputZero,
   input  wire logic                    frameValid,
   input  wire logic [15:0]             frameWord,
   output var  logic [7:0]              readData,
   output var  logic [4:0]              readAddr,
   output var  logic                    parityError,
   output var  logic                    frameToggleBit,
   output var  rdcfg_pkg::rdcfg_cfg_t   config_o,
   output var  logic                    channelsDisabled,
   output var  logic [7:0]              outputDrive,
   output var  logic [23:0]             ledGeneratorPeriod,
   output var  logic [23:0]             generalGeneratorPeriod
);

   // ****************************************
   // Frame decode
   // ****************************************
   function automatic logic oddParityOk(input logic [15:0] w);
      oddParityOk = ^w[15:1];
   endfunction

   rdcfg_pkg::rdcfg_frame_t frame;
   logic                    frameOk;
   logic                    writeStrobe;
   logic                    softResetHit;
   logic                    pinResetHit;
   logic                    bankReset;

   assign frame        = frameWord;
   assign frameOk      = frameValid && oddParityOk(frameWord);
   assign writeStrobe  = frameOk && frame.write;
   assign softResetHit = writeStrobe && frame.addr == rdcfg_pkg::ADDR_SOFTCTL
                         && frame.data[rdcfg_pkg::SOFT_RST_BIT];
   // Pin only acts when unmasked; pin level is synchronous
   assign pinResetHit  = !externalResetPin_n && config_o.resetUnmask;
   assign bankReset    = softResetHit || pinResetHit || logicSupplyUndervoltage;

   // ****************************************
   // Writable fields
   // ****************************************
   // Soft reset bit is never stored, so it reads back zero and self-clears
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         config_o <= '0;
         config_o.inputZeroMapping <= rdcfg_pkg::RST_INZERO;
      end else if (bankReset) begin
         config_o <= '0;
         config_o.inputZeroMapping <= rdcfg_pkg::RST_INZERO;
      end else if (writeStrobe) begin
         unique case (frame.addr)
            rdcfg_pkg::ADDR_TOPOLOGY: begin
               config_o.highSide      <= frame.data[7:rdcfg_pkg::TOPO_LSB];
               config_o.disableUnmask <= frame.data[rdcfg_pkg::DIS_UNMASK_BIT];
               config_o.resetUnmask   <= frame.data[rdcfg_pkg::RST_UNMASK_BIT];
            end
            rdcfg_pkg::ADDR_SOFTCTL: begin
               config_o.activeModeRequest   <= frame.data[rdcfg_pkg::ACTIVE_BIT];
               config_o.ledGeneratorDivider <= frame.data[1:0];
            end
            rdcfg_pkg::ADDR_TRIMGEN: begin
               config_o.frequencyTrim           <= rdcfg_pkg::rdcfg_trim_t'(frame.data[3:2]);
               config_o.generalGeneratorDivider <= frame.data[1:0];
            end
            rdcfg_pkg::ADDR_INRUSH: config_o.inrushMode       <= frame.data;
            rdcfg_pkg::ADDR_OUTCTL: config_o.outputOnOff      <= frame.data;
            rdcfg_pkg::ADDR_INZERO: config_o.inputZeroMapping <= frame.data;
            default: ;
         endcase
      end
   end

   // ****************************************
   // Read-back
   // ****************************************
   logic [7:0] readMux;

   always_comb begin
      readMux = 8'h00;
      unique case (frame.addr)
         rdcfg_pkg::ADDR_IDENT:    readMux = rdcfg_pkg::IDENT_CODE;
         rdcfg_pkg::ADDR_TOPOLOGY: readMux = {config_o.highSide, config_o.disableUnmask,
                                              config_o.resetUnmask};
         rdcfg_pkg::ADDR_SOFTCTL:  readMux = {1'b0, config_o.activeModeRequest, 4'h0,
                                              config_o.ledGeneratorDivider};
         rdcfg_pkg::ADDR_TRIMGEN:  readMux = {4'h0, config_o.frequencyTrim,
                                              config_o.generalGeneratorDivider};
         rdcfg_pkg::ADDR_INRUSH:   readMux = config_o.inrushMode;
         rdcfg_pkg::ADDR_OUTCTL:   readMux = config_o.outputOnOff;
         rdcfg_pkg::ADDR_INZERO:   readMux = config_o.inputZeroMapping;
         default:                  readMux = 8'h00;
      endcase
   end

   // Answer is presented in the next frame, so hold it until then
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         readData       <= 8'h00;
         readAddr       <= 5'h00;
         frameToggleBit <= 1'b0;
      end else if (frameOk) begin
         readData       <= readMux;
         readAddr       <= frame.addr;
         frameToggleBit <= frame.toggle;
      end
   end

   // Error flag covers the last frame only
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         parityError <= 1'b0;
      end else if (frameValid) begin
         parityError <= !oddParityOk(frameWord);
      end
   end

   // ****************************************
   // Channel drive
   // ****************************************
   logic [7:0] next_outputDrive;

   always_comb begin
      for (int n = 0; n < 8; n++) begin
         next_outputDrive[n] = config_o.outputOnOff[n]
                               || (config_o.inputZeroMapping[n] && parallelInputZero);
      end
      if (channelsDisabled) begin
         next_outputDrive = 8'h00;
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         outputDrive      <= 8'h00;
         channelsDisabled <= 1'b0;
      end else begin
         outputDrive      <= next_outputDrive;
         channelsDisabled <= !externalDisablePin_n && config_o.disableUnmask;
      end
   end

   // ****************************************
   // Generator periods
   // ****************************************
   rdcfg_period_calc ledPeriod (
      .sys_clk      (sys_clk),
      .resetn       (resetn),
      .divider      (config_o.ledGeneratorDivider),
      .trim         (config_o.frequencyTrim),
      .periodCycles (ledGeneratorPeriod)
   );

   rdcfg_period_calc genPeriod (
      .sys_clk      (sys_clk),
      .resetn       (resetn),
      .divider      (config_o.generalGeneratorDivider),
      .trim         (config_o.frequencyTrim),
      .periodCycles (generalGeneratorPeriod)
   );

endmodule
`default_nettype wire

/* File: core/rdcfg_pkg.sv */
// Package of the relay driver configuration bank: map, fields, reset values.
// Assumes a 10 MHz system clock and a frame decoder that delivers whole frames.
`default_nettype none
package rdcfg_pkg;

   // ****************************************
   // Register offsets
   // ****************************************
   localparam logic [4:0] ADDR_IDENT    = 5'h00;
   localparam logic [4:0] ADDR_TOPOLOGY = 5'h01;
   localparam logic [4:0] ADDR_SOFTCTL  = 5'h02;
   localparam logic [4:0] ADDR_TRIMGEN  = 5'h03;
   localparam logic [4:0] ADDR_INRUSH   = 5'h04;
   localparam logic [4:0] ADDR_RESERVED = 5'h05;
   localparam logic [4:0] ADDR_OUTCTL   = 5'h06;
   localparam logic [4:0] ADDR_INZERO   = 5'h07;

   // ****************************************
   // Field positions
   // ****************************************
   localparam int TOPO_LSB       = 2;
   localparam int DIS_UNMASK_BIT = 1;
   localparam int RST_UNMASK_BIT = 0;
   localparam int SOFT_RST_BIT   = 7;
   localparam int ACTIVE_BIT     = 6;
   localparam int FRAME_CMD_BIT  = 15;
   localparam int FRAME_ADDR_LSB = 10;
   localparam int FRAME_DATA_LSB = 2;
   localparam int FRAME_PAR_BIT  = 1;

   // ****************************************
   // Reset values
   // ****************************************
   localparam logic [7:0] RST_ZERO   = 8'h00;
   localparam logic [7:0] RST_INZERO = 8'h04;
   // Arbitrary neutral identifier value
   localparam logic [7:0] IDENT_CODE = 8'h5A;

   // ****************************************
   // Generator frequency, in centihertz
   // ****************************************
   localparam int FREQ_CHZ_0 = 12250;
   localparam int FREQ_CHZ_1 = 24510;
   localparam int FREQ_CHZ_2 = 49020;
   localparam int FREQ_CHZ_3 = 98040;
   localparam int TRIM_PCT   = 15;
   localparam int CLK_HZ     = 10000000;

   typedef enum logic [1:0] {
      RDCFG_TRIM_NONE = 2'b00,
      RDCFG_TRIM_DOWN = 2'b01,
      RDCFG_TRIM_UP   = 2'b10,
      RDCFG_TRIM_NON2 = 2'b11
   } rdcfg_trim_t;

   typedef struct packed {
      logic       write;
      logic [4:0] addr;
      logic [7:0] data;
      logic       parity;
      logic       toggle;
   } rdcfg_frame_t;

   typedef struct packed {
      logic [5:0]  highSide;
      logic        disableUnmask;
      logic        resetUnmask;
      logic        activeModeRequest;
      logic [1:0]  ledGeneratorDivider;
      rdcfg_trim_t frequencyTrim;
      logic [1:0]  generalGeneratorDivider;
      logic [7:0]  inrushMode;
      logic [7:0]  outputOnOff;
      logic [7:0]  inputZeroMapping;
   } rdcfg_cfg_t;

endpackage
`default_nettype wire

/* File: core/rdcfg_period_calc.sv */
// Converts a divider code and trim into a generator period in sys_clk cycles.
// Assumes a static configuration; result is registered.
`default_nettype none
module rdcfg_period_calc (
   input  wire logic               sys_clk,
   input  wire logic               resetn,
   input  wire logic [1:0]         divider,
   input  wire rdcfg_pkg::rdcfg_trim_t trim,
   output var  logic [23:0]        periodCycles
);

   logic [31:0] baseCycles;
   logic [31:0] trimmed;

   always_comb begin
      unique case (divider)
         // Scale before dividing so centihertz keep their precision
         2'b00: baseCycles = 32'(rdcfg_pkg::CLK_HZ * 100 / rdcfg_pkg::FREQ_CHZ_0);
         2'b01: baseCycles = 32'(rdcfg_pkg::CLK_HZ * 100 / rdcfg_pkg::FREQ_CHZ_1);
         2'b10: baseCycles = 32'(rdcfg_pkg::CLK_HZ * 100 / rdcfg_pkg::FREQ_CHZ_2);
         2'b11: baseCycles = 32'(rdcfg_pkg::CLK_HZ * 100 / rdcfg_pkg::FREQ_CHZ_3);
      endcase
   end

   // Frequency down by 15 % lengthens the period, up shortens it
   always_comb begin
      unique case (trim)
         rdcfg_pkg::RDCFG_TRIM_DOWN:
            trimmed = baseCycles * 32'd100 / 32'(100 - rdcfg_pkg::TRIM_PCT);
         rdcfg_pkg::RDCFG_TRIM_UP:
            trimmed = baseCycles * 32'd100 / 32'(100 + rdcfg_pkg::TRIM_PCT);
         default:
            trimmed = baseCycles;
      endcase
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         periodCycles <= 24'h000000;
      end else begin
         periodCycles <= trimmed[23:0];
      end
   end

endmodule
`default_nettype wire

/* File: verif/rdcfg_assertions.sv */
// Port checker for the relay driver configuration bank.
// Assumes the single sys_clk domain; bound onto rdcfg_regs below.
`default_nettype none
module rdcfg_assertions (
   input wire logic                  sys_clk,
   input wire logic                  resetn,
   input wire logic                  logicSupplyUndervoltage,
   input wire logic                  externalResetPin_n,
   input wire logic                  externalDisablePin_n,
   input wire logic                  frameValid,
   input wire logic [15:0]           frameWord,
   input wire logic [7:0]            readData,
   input wire logic                  parityError,
   input wire rdcfg_pkg::rdcfg_cfg_t config_o,
   input wire logic [7:0]            outputDrive
);
   wire       good  = frameValid && (^frameWord[15:1]);
   wire       rd    = good && !frameWord[15];
   wire       wr    = good && frameWord[15];
   wire [4:0] adr   = frameWord[14:10];
   wire       quiet = !logicSupplyUndervoltage && externalResetPin_n;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   // ********
   // Checks
   // ********
   ident_read_a: assert property (rd && adr == 5'h00 |-> ##[1:2] readData == 8'h5A)
      else $error("identifier read wrong");
   reset_default_a: assert property ($rose(resetn) |->
      config_o.inputZeroMapping == 8'h04 && config_o.highSide == 6'h00)
      else $error("defaults wrong after reset");
   uv_reset_a: assert property (logicSupplyUndervoltage |=>
      config_o.inputZeroMapping == 8'h04 && config_o.outputOnOff == 8'h00)
      else $error("undervoltage did not reset");
   pin_reset_a: assert property (!externalResetPin_n && config_o.resetUnmask |=>
      config_o.outputOnOff == 8'h00 && !config_o.resetUnmask)
      else $error("unmasked reset pin ignored");
   pin_masked_a: assert property (!externalResetPin_n && !config_o.resetUnmask
      && !frameValid && !logicSupplyUndervoltage |=> $stable(config_o))
      else $error("masked reset pin acted");
   disable_gate_a: assert property (!externalDisablePin_n && config_o.disableUnmask
      |-> ##[1:2] outputDrive == 8'h00)
      else $error("disable pin did not stop outputs");
   soft_reset_a: assert property (wr && adr == 5'h02 && frameWord[9] |=>
      config_o.inputZeroMapping == 8'h04 && !config_o.activeModeRequest)
      else $error("soft reset did not act");
   active_req_a: assert property (wr && adr == 5'h02 && !frameWord[9] && quiet |=>
      config_o.activeModeRequest == $past(frameWord[8]))
      else $error("active mode request not stored");
   ro_write_a: assert property (wr && (adr == 5'h00 || adr == 5'h05) && quiet
      |=> $stable(config_o))
      else $error("read-only write changed state");
   parity_flag_a: assert property (frameValid && !(^frameWord[15:1]) |-> ##[1:2] parityError)
      else $error("bad parity not flagged");
endmodule
bind rdcfg_regs rdcfg_assertions chk (.sys_clk, .resetn, .logicSupplyUndervoltage,
   .externalResetPin_n, .externalDisablePin_n, .frameValid, .frameWord, .readData,
   .parityError, .config_o, .outputDrive);
`default_nettype wire

/* File: verif/rdcfg_master_model.sv */
// Frame sender standing in for the serial master.
// Assumes the bench drives frames through task send.
`default_nettype none
module rdcfg_master_model (
   input  wire logic        sys_clk,
   output var  logic        frameValid,
   output var  logic [15:0] frameWord
);
   timeunit 1ns;
   timeprecision 1ns;
   logic toggle = 1'b0;
   initial begin
      frameValid = 1'b0;
      frameWord = 16'h0000;
   end
   task automatic send(input logic w, input logic [4:0] a, input logic [7:0] d, input logic bad);
      logic [15:0] f;
      f = {w, a, d, 2'b00};
      f[1] = ~^f[15:2] ^ bad;
      f[0] = toggle;
      @(posedge sys_clk);
      #10;
      frameValid = 1'b1;
      frameWord = f;
      toggle = ~toggle;
      @(posedge sys_clk);
      #10;
      frameValid = 1'b0;
      // Stale word is inverted so nothing reads it by luck
      frameWord = ~f;
   endtask
endmodule
`default_nettype wire

/* File: verif/test_relay_driver_config_regs.sv */
// Self-checking bench for the configuration bank.
// Assumes frames come from rdcfg_master_model, 100 ns clock.
`default_nettype none
module test_relay_driver_config_regs;
   timeunit 1ns;
   timeprecision 1ns;
   logic                  sys_clk, resetn, uv, rstPin_n, disPin_n, in0;
   logic                  frameValid, parityError, channelsDisabled;
   logic [15:0]           frameWord;
   logic [7:0]            readData, outputDrive;
   logic [23:0]           ledPer, genPer;
   rdcfg_pkg::rdcfg_cfg_t cfg;
   int                    failures = 0, checkCount = 0, cycles = 0;
   logic [7:0] rv [8] = '{8'h5A, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h04};
   logic [7:0] wd [8] = '{8'hFF, 8'hA6, 8'h7F, 8'hFF, 8'h5A, 8'hFF, 8'h81, 8'hC3};
   logic [7:0] ex [8] = '{8'h5A, 8'hA6, 8'h43, 8'h0F, 8'h5A, 8'h00, 8'h81, 8'hC3};
   rdcfg_master_model m (.sys_clk, .frameValid, .frameWord);
   rdcfg_regs dut (.sys_clk, .resetn, .logicSupplyUndervoltage(uv),
      .externalResetPin_n(rstPin_n), .externalDisablePin_n(disPin_n),
      .parallelInputZero(in0), .frameValid, .frameWord, .readData, .readAddr(),
      .parityError, .frameToggleBit(), .config_o(cfg), .channelsDisabled, .outputDrive,
      .ledGeneratorPeriod(ledPer), .generalGeneratorPeriod(genPer));
   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #10;
   endtask
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      checkCount++;
      if (g !== e) begin
         failures++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic rd(input logic [4:0] a, input logic [7:0] e);
      m.send(1'b0, a, 8'h00, 1'b0);
      tick(2);
      chk("readData", e, readData);
   endtask
   task automatic endOfTest();
      $display("checks %0d mismatches %0d", checkCount, failures);
      if (failures == 0 && checkCount > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // Budget is about 140 cycles; ceiling leaves wide margin
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 3000) begin
         failures++;
         endOfTest();
      end
   end
   initial begin
      {resetn, uv, rstPin_n, disPin_n, in0} = 5'h07;
      tick(4);
      resetn = 1'b1;
      for (int i = 0; i < 8; i++) rd(5'(i), rv[i]);
      // 10 MHz over 122.5 Hz is 81632 cycles, 0x013EE0
      chk("ledGeneratorPeriod", 8'hE0, ledPer[7:0]);
      chk("ledGeneratorPeriod", 8'h3E, ledPer[15:8]);
      chk("generalGeneratorPeriod", 8'h01, genPer[23:16]);
      $display("test reset values done");
      for (int i = 0; i < 8; i++) m.send(1'b1, 5'(i), wd[i], 1'b0);
      for (int i = 0; i < 8; i++) rd(5'(i), ex[i]);
      chk("highSide", 8'h29, {2'b00, cfg.highSide});
      chk("outputDrive", 8'hC3, outputDrive);
      in0 = 1'b0;
      tick(2);
      chk("outputDrive", 8'h81, outputDrive);
      $display("test write readback done");
      disPin_n = 1'b0;
      tick(2);
      chk("outputDrive", 8'h00, outputDrive);
      chk("channelsDisabled", 8'h01, {7'h00, channelsDisabled});
      m.send(1'b1, 5'h01, 8'hA4, 1'b0);
      tick(2);
      chk("outputDrive", 8'h81, outputDrive);
      disPin_n = 1'b1;
      rstPin_n = 1'b0;
      rd(5'h06, 8'h81);
      rstPin_n = 1'b1;
      m.send(1'b1, 5'h01, 8'hA5, 1'b0);
      rstPin_n = 1'b0;
      tick(2);
      rstPin_n = 1'b1;
      rd(5'h06, 8'h00);
      rd(5'h01, 8'h00);
      $display("test pins done");
      m.send(1'b1, 5'h06, 8'h81, 1'b0);
      m.send(1'b1, 5'h02, 8'hC1, 1'b0);
      rd(5'h06, 8'h00);
      rd(5'h02, 8'h00);
      m.send(1'b1, 5'h07, 8'h00, 1'b0);
      uv = 1'b1;
      tick(2);
      uv = 1'b0;
      rd(5'h07, 8'h04);
      $display("test soft and undervoltage reset done");
      m.send(1'b1, 5'h06, 8'hFF, 1'b0);
      m.send(1'b1, 5'h06, 8'h00, 1'b1);
      tick(2);
      chk("parityError", 8'h01, {7'h00, parityError});
      rd(5'h06, 8'hFF);
      chk("parityError", 8'h00, {7'h00, parityError});
      $display("test parity done");
      endOfTest();
   end
endmodule
`default_nettype wire
